// ===== pmb_pkg.sv
// Package for program map and boot select block
package pmb_pkg;
  localparam int PMB_ADDR_W = 21;
  localparam int PMB_UPPER_BIT = 16;
  localparam logic [20:0] PMB_BOOT_INT     = 21'h040000;
  localparam logic [20:0] PMB_WDOG_INT     = 21'h040002;
  localparam logic [20:0] PMB_BOOT_EXT16   = 21'h000000;
  localparam logic [20:0] PMB_WDOG_EXT16   = 21'h000002;
  localparam logic [20:0] PMB_BFLASH_LO    = 21'h040000;
  localparam logic [20:0] PMB_BFLASH_HI    = 21'h043FFF;
  localparam logic [20:0] PMB_EXT16_HI     = 21'h00FFFF;
  localparam logic [20:0] PMB_EXT20_HI     = 21'h0FFFFF;
  localparam logic [20:0] PMB_SHADOW_HI    = 21'h02FFFF;
  localparam logic [20:0] PMB_FLASH0_HI    = 21'h01FFFF;
  localparam logic [20:0] PMB_FLASH1_HI    = 21'h03FFFF;
  localparam logic [20:0] PMB_PIN_FREE_HI  = 21'h00000F;

  typedef enum logic [1:0] {
    PMB_TGT_INT   = 2'h0,
    PMB_TGT_BOOT  = 2'h1,
    PMB_TGT_EXT   = 2'h2,
    PMB_TGT_NONE  = 2'h3
  } pmb_tgt_t;

  typedef struct packed {
    logic program_map_select;
    logic secure_state_latch;
    logic wide_bus;
    logic legacy_strobes;
  } pmb_state_t;

  typedef struct packed {
    pmb_tgt_t    target;
    logic        flash_block;
    logic        upper_address_bit;
    logic        pins_needed;
  } pmb_decode_t;
endpackage : pmb_pkg

// ===== pmb_map.sv
// Program map and boot select logic
`timescale 1ns/1ps
`default_nettype none
module pmb_map
  import pmb_pkg::*;
(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              srst,
  // Straps and security
  input  wire logic              external_boot_strap,
  input  wire logic              address_width_strap,
  input  wire logic              flash_unsecured,
  // Software control
  input  wire logic              map_select_wr,
  input  wire logic              map_select_wdata,
  input  wire logic              strobes_release,
  input  wire logic              upper_pins_enable,
  // Fetch address
  input  wire logic [20:0]       prog_addr,
  // Status and decode
  output var  logic              program_map_select,
  output var  logic              secure_state_latch,
  output var  logic              wide_bus,
  output var  logic              legacy_strobes,
  output var  logic [20:0]       reset_vector,
  output var  logic [20:0]       watchdog_vector,
  output var  pmb_decode_t       decode
);

  typedef struct packed {
    pmb_state_t  st;
    logic        cfg_done;
    logic [20:0] rst_vec;
    logic [20:0] wdg_vec;
    pmb_decode_t dec;
  } pmb_all_t;

  pmb_all_t cur;
  pmb_all_t next_cur;

  function automatic logic pmb_in(input logic [20:0] a, input logic [20:0] lo, input logic [20:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction : pmb_in

  always_comb begin
    next_cur = cur;
    if (!cur.cfg_done) begin
      // Configuration is caught on the first clock after reset release, never under reset
      next_cur.cfg_done = 1'b1;
      next_cur.st.secure_state_latch = flash_unsecured;
      next_cur.st.program_map_select = external_boot_strap & flash_unsecured;
      next_cur.st.wide_bus = address_width_strap;
      next_cur.st.legacy_strobes = 1'b1;
      if (external_boot_strap & flash_unsecured) begin
        next_cur.rst_vec = address_width_strap ? PMB_BOOT_INT : PMB_BOOT_EXT16;
        next_cur.wdg_vec = address_width_strap ? PMB_WDOG_INT : PMB_WDOG_EXT16;
      end else begin
        next_cur.rst_vec = PMB_BOOT_INT;
        next_cur.wdg_vec = PMB_WDOG_INT;
      end
    end else begin
      // Writes to the select bit are dead when the part came up secured
      if (map_select_wr && cur.st.secure_state_latch) begin
        next_cur.st.program_map_select = map_select_wdata;
      end
      if (strobes_release) begin
        next_cur.st.legacy_strobes = 1'b0;
      end
    end
    next_cur.dec.flash_block = (prog_addr > PMB_FLASH0_HI);
    next_cur.dec.upper_address_bit = cur.st.wide_bus & prog_addr[PMB_UPPER_BIT];
    next_cur.dec.pins_needed = cur.st.program_map_select && !upper_pins_enable
                               && (prog_addr > PMB_PIN_FREE_HI);
    if (!cur.st.program_map_select) begin
      if (pmb_in(prog_addr, PMB_BFLASH_LO, PMB_BFLASH_HI)) begin
        next_cur.dec.target = PMB_TGT_BOOT;
      end else if (prog_addr <= PMB_FLASH1_HI) begin
        next_cur.dec.target = PMB_TGT_INT;
      end else begin
        next_cur.dec.target = upper_pins_enable ? PMB_TGT_EXT : PMB_TGT_NONE;
      end
    end else if (!cur.st.wide_bus) begin
      if (prog_addr <= PMB_EXT16_HI) begin
        next_cur.dec.target = PMB_TGT_EXT;
      end else if (pmb_in(prog_addr, PMB_BFLASH_LO, PMB_BFLASH_HI)) begin
        next_cur.dec.target = PMB_TGT_BOOT;
      end else if (prog_addr <= PMB_FLASH1_HI) begin
        next_cur.dec.target = PMB_TGT_INT;
      end else begin
        next_cur.dec.target = upper_pins_enable ? PMB_TGT_EXT : PMB_TGT_NONE;
      end
    end else begin
      if (pmb_in(prog_addr, PMB_BFLASH_LO, PMB_BFLASH_HI)) begin
        next_cur.dec.target = PMB_TGT_EXT;
      end else if (prog_addr <= PMB_SHADOW_HI) begin
        next_cur.dec.target = PMB_TGT_INT;
      end else if (prog_addr <= PMB_EXT20_HI) begin
        next_cur.dec.target = PMB_TGT_INT;
      end else begin
        next_cur.dec.target = upper_pins_enable ? PMB_TGT_EXT : PMB_TGT_NONE;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cur <= '0;
      cur.st.legacy_strobes <= 1'b1;
      cur.rst_vec <= PMB_BOOT_INT;
      cur.wdg_vec <= PMB_WDOG_INT;
      cur.dec.target <= PMB_TGT_NONE;
    end else begin
      cur <= next_cur;
    end
  end

  assign program_map_select = cur.st.program_map_select;
  assign secure_state_latch = cur.st.secure_state_latch;
  assign wide_bus           = cur.st.wide_bus;
  assign legacy_strobes     = cur.st.legacy_strobes;
  assign reset_vector       = cur.rst_vec;
  assign watchdog_vector    = cur.wdg_vec;
  assign decode             = cur.dec;

  sequence s_cfg_secured;
    !cur.cfg_done && !flash_unsecured;
  endsequence

  sequence s_cfg_step;
    !cur.cfg_done;
  endsequence

  sequence s_cfg_ext_wide;
    !cur.cfg_done && external_boot_strap && flash_unsecured && address_width_strap;
  endsequence

  a_secured_no_ext: assert property (@(posedge clock) disable iff (srst)
    s_cfg_secured |=> !program_map_select && !secure_state_latch && reset_vector == PMB_BOOT_INT)
    else $error("secured part did not fall back to internal boot");
  a_select_locked: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done && !secure_state_latch |=> !program_map_select)
    else $error("map select changed on a secured part");
  a_latch_stable: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done |=> $stable(secure_state_latch))
    else $error("security latch changed after reset");
  a_select_write: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done && secure_state_latch && map_select_wr |=> program_map_select == $past(map_select_wdata))
    else $error("map select write lost");
  a_ext16_vec: assert property (@(posedge clock) disable iff (srst)
    !cur.cfg_done && external_boot_strap && flash_unsecured && !address_width_strap
      |=> reset_vector == PMB_BOOT_EXT16 && watchdog_vector == PMB_WDOG_EXT16)
    else $error("external 16-bit boot vectors wrong");
  a_int_boot_fetch: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done && !program_map_select && prog_addr == PMB_BOOT_INT |=> decode.target == PMB_TGT_BOOT)
    else $error("internal boot location not boot flash");
  a_wide_bootflash: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done && program_map_select && wide_bus && prog_addr == PMB_WDOG_INT
      |=> decode.target == PMB_TGT_EXT)
    else $error("20-bit boot not mapped external");
  a_high_unreach: assert property (@(posedge clock) disable iff (srst)
    !upper_pins_enable && prog_addr > PMB_EXT20_HI |=> decode.target == PMB_TGT_NONE)
    else $error("high external memory reachable");
  a_legacy_strobes: assert property (@(posedge clock) disable iff (srst)
    !cur.cfg_done |=> legacy_strobes)
    else $error("strobes not legacy after reset");
  // Each configuration output except legacy_strobes is tied back to the straps seen on the configuration edge
  a_width_strap: assert property (@(posedge clock) disable iff (srst)
    s_cfg_step |=> wide_bus == $past(address_width_strap))
    else $error("width strap not latched");
  a_map_from_strap: assert property (@(posedge clock) disable iff (srst)
    s_cfg_step |=> program_map_select == $past(external_boot_strap && flash_unsecured))
    else $error("map select not loaded from gated strap");
  a_latch_from_flash: assert property (@(posedge clock) disable iff (srst)
    s_cfg_step |=> secure_state_latch == $past(flash_unsecured))
    else $error("security latch not loaded at reset");
  a_int_vectors: assert property (@(posedge clock) disable iff (srst)
    !cur.cfg_done && !(external_boot_strap && flash_unsecured)
      |=> reset_vector == PMB_BOOT_INT && watchdog_vector == PMB_WDOG_INT)
    else $error("internal boot vectors wrong");
  a_wide_vectors: assert property (@(posedge clock) disable iff (srst)
    s_cfg_ext_wide |=> reset_vector == PMB_BOOT_INT && watchdog_vector == PMB_WDOG_INT)
    else $error("external 20-bit boot vectors wrong");
  a_int_map_fetch: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done && !program_map_select && prog_addr <= PMB_FLASH1_HI |=> decode.target == PMB_TGT_INT)
    else $error("internal map fetch not internal");
  a_narrow_ext: assert property (@(posedge clock) disable iff (srst)
    program_map_select && !wide_bus && prog_addr <= PMB_EXT16_HI |=> decode.target == PMB_TGT_EXT)
    else $error("narrow external window not external");
  a_narrow_high: assert property (@(posedge clock) disable iff (srst)
    program_map_select && !wide_bus && !upper_pins_enable && prog_addr > PMB_BFLASH_HI
      |=> decode.target == PMB_TGT_NONE)
    else $error("narrow bus reached high memory");
  a_shadow_int: assert property (@(posedge clock) disable iff (srst)
    program_map_select && wide_bus && prog_addr <= PMB_SHADOW_HI |=> decode.target == PMB_TGT_INT)
    else $error("shadowed program space not internal");
  // Both sides of the block split are checked so a stuck flag cannot pass
  a_block_low: assert property (@(posedge clock) disable iff (srst)
    prog_addr <= PMB_FLASH0_HI |=> !decode.flash_block)
    else $error("lower flash block misreported");
  a_block_high: assert property (@(posedge clock) disable iff (srst)
    prog_addr > PMB_FLASH0_HI && prog_addr <= PMB_FLASH1_HI |=> decode.flash_block)
    else $error("upper flash block misreported");
  a_upper_narrow: assert property (@(posedge clock) disable iff (srst)
    !wide_bus |=> !decode.upper_address_bit)
    else $error("upper address bit driven on narrow bus");
  a_upper_wide: assert property (@(posedge clock) disable iff (srst)
    wide_bus && prog_addr[PMB_UPPER_BIT] |=> decode.upper_address_bit)
    else $error("upper address bit lost on wide bus");
  a_strobes_release: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done && strobes_release |=> !legacy_strobes)
    else $error("strobes not released");
  a_strobes_sticky: assert property (@(posedge clock) disable iff (srst)
    cur.cfg_done && !legacy_strobes |=> !legacy_strobes)
    else $error("legacy strobes came back without reset");
endmodule : pmb_map
`default_nettype wire

// ===== pmb_ext_mem.sv
// External program memory model
`timescale 1ns/1ps
`default_nettype none
module pmb_ext_mem
  import pmb_pkg::*;
(
  // Fetch side
  input  wire logic        clock,
  input  wire pmb_decode_t decode,
  input  wire logic [20:0] prog_addr,
  input  wire logic        pins_ok,
  // Data back
  output var  logic [15:0] rdata
);
  always_ff @(posedge clock) begin
    // Unconfigured pins never reach words at 0x10 up; an idle bus drifts, not holds
    if (decode.target == PMB_TGT_EXT && (prog_addr <= PMB_PIN_FREE_HI || pins_ok)) begin
      rdata <= prog_addr[15:0] ^ 16'hA5A5;
    end else begin
      rdata <= ~rdata;
    end
  end
endmodule : pmb_ext_mem
`default_nettype wire

// ===== testbench.sv
// Bench for program map and boot select
`timescale 1ns/1ps
`default_nettype none
module testbench
  import pmb_pkg::*;
;
  logic        clock, srst, ext, wid, unsec, wr, wdata, rel, upe, pms, ssl, wb, ls;
  logic [20:0] addr, rv, wv;
  logic [15:0] rdata;
  pmb_decode_t dec;
  logic [31:0] seed = 32'hBF3E0929;
  int          err_total, checks;
  pmb_map dut (.clock(clock), .srst(srst), .external_boot_strap(ext), .address_width_strap(wid),
    .flash_unsecured(unsec), .map_select_wr(wr), .map_select_wdata(wdata), .strobes_release(rel),
    .upper_pins_enable(upe), .prog_addr(addr), .program_map_select(pms), .secure_state_latch(ssl),
    .wide_bus(wb), .legacy_strobes(ls), .reset_vector(rv), .watchdog_vector(wv), .decode(dec));
  pmb_ext_mem mem (.clock(clock), .decode(dec), .prog_addr(addr), .pins_ok(upe), .rdata(rdata));
  initial begin
    clock = 0;
    forever #2.5 clock = ~clock;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // Only an external boot on the narrow bus leaves the boot flash vectors
  function automatic logic [20:0] vec(input logic x, input logic w, input logic wd);
    if (x && !w) return wd ? PMB_WDOG_EXT16 : PMB_BOOT_EXT16;
    return wd ? PMB_WDOG_INT : PMB_BOOT_INT;
  endfunction : vec
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [20:0] got, input logic [20:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", n, exp, got);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic boot(input logic u, input logic e, input logic w);
    {srst, unsec, ext, wid} = {1'b1, u, e, w};
    cyc(20);
    srst = 0;
    cyc(2);
    chk("latch", ssl, u);
    chk("map", pms, e & u);
    chk("strobes", ls, 1);
    chk("boot vector", rv, vec(e & u, w, 0));
    chk("watchdog vector", wv, vec(e & u, w, 1));
    chk("wide", wb, w);
    unsec = ~u;
    cyc(2);
    chk("latch held", ssl, u);
    $display("boot %b%b%b done", u, e, w);
  endtask : boot
  task automatic look(input logic [20:0] a, input pmb_tgt_t t);
    addr = a;
    cyc(1);
    chk("target", dec.target, t);
  endtask : look
  task automatic wr_map(input logic d);
    {wr, wdata} = {1'b1, d};
    cyc(1);
    wr = 0;
    cyc(1);
  endtask : wr_map
  initial begin
    {srst, ext, wid, unsec, wr, wdata, rel, upe, addr} = '0;
    for (int m = 0; m < 8; m++) begin
      boot(m[0], m[1], m[2]);
    end
    boot(1, 1, 0);
    look(21'h000005, PMB_TGT_EXT);
    look(21'h100000, PMB_TGT_NONE);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      upe = seed[31];
      look({5'h00, seed[15:0] | 16'h0010}, PMB_TGT_EXT);
      chk("pins", dec.pins_needed, !upe);
      cyc(1);
      if (upe) chk("ext data", rdata, addr[15:0] ^ 16'hA5A5);
    end
    rel = 1;
    cyc(1);
    rel = 0;
    cyc(1);
    chk("strobes off", ls, 0);
    wr_map(0);
    chk("map clear", pms, 0);
    look(21'h040010, PMB_TGT_BOOT);
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      look({3'h0, seed[17:0]}, PMB_TGT_INT);
      chk("block", dec.flash_block, seed[17]);
    end
    wr_map(1);
    chk("map set", pms, 1);
    look(21'h000020, PMB_TGT_EXT);
    look(21'h010000, PMB_TGT_INT);
    chk("a16 narrow", dec.upper_address_bit, 0);
    look(21'h040000, PMB_TGT_BOOT);
    $display("narrow bus done");
    upe = 0;
    boot(1, 1, 1);
    look(21'h040000, PMB_TGT_EXT);
    look(21'h010000, PMB_TGT_INT);
    chk("a16", dec.upper_address_bit, 1);
    look(21'h100000, PMB_TGT_NONE);
    upe = 1;
    look(21'h100000, PMB_TGT_EXT);
    upe = 0;
    boot(0, 1, 1);
    wr_map(1);
    chk("map refused", pms, 0);
    look(21'h000005, PMB_TGT_INT);
    $display("secure done");
    wrap_up();
  end
  // Cuts a hang short
  initial begin
    repeat (20000) @(posedge clock);
    err_total++;
    wrap_up();
  end
endmodule : testbench
`default_nettype wire
